//--- design/rxcfg_pkg.sv
package rxcfg_pkg;
  localparam int FRAME_BITS = 15;
  localparam int REG_W = 12;
  // operating register field positions (register bit 11 = frame bit 3)
  localparam int OP_BAUD_LSB = 10;
  localparam int OP_CHECK_LSB = 8;
  localparam int OP_MOD_BIT = 7;
  localparam int OP_SLEEP_LSB = 2;
  localparam int OP_EXT_BIT = 1;
  localparam int OP_NS_BIT = 0;
  localparam int LIM_LO_LSB = 6;
  localparam logic [11:0] OP_RESET = 12'h119;
  localparam logic [11:0] LIM_RESET = 12'h569;
  // timing, ns and clock cycles
  localparam int CLK_NS = 10;
  localparam int CLOCK_ISSUE_DELAY_NS = 100;
  localparam int CLOCK_ISSUE_CYC = (CLOCK_ISSUE_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLK_PULSE_CYC = 4;
  localparam int SYNC_CYC = 8;
  localparam int START_LOW_MIN_CYC = 64;
  localparam int END_PULSE_BASE_CYC = 16;
  localparam int SLEEP_UNIT_CYC = 1024;
  typedef enum logic [1:0] {RXCFG_POLL, RXCFG_STARTUP, RXCFG_CHECK, RXCFG_RECV} rxcfg_mode_t;
  typedef enum logic [1:0] {RXCFG_CMD_OFF, RXCFG_CMD_OP, RXCFG_CMD_LIM} rxcfg_cmd_t;

  function automatic logic [3:0] rxcfg_scale(input logic [1:0] baud);
    case (baud)
      2'b00: rxcfg_scale = 4'd8;
      2'b01: rxcfg_scale = 4'd4;
      2'b10: rxcfg_scale = 4'd2;
      default: rxcfg_scale = 4'd1;
    endcase
  endfunction : rxcfg_scale

  function automatic logic [3:0] rxcfg_checks(input logic [1:0] sel);
    case (sel)
      2'b00: rxcfg_checks = 4'd0;
      2'b01: rxcfg_checks = 4'd3;
      2'b10: rxcfg_checks = 4'd6;
      default: rxcfg_checks = 4'd9;
    endcase
  endfunction : rxcfg_checks
endpackage : rxcfg_pkg

//--- design/rxcfg_frame_if.sv
`timescale 1ns/1ps
interface rxcfg_frame_if;
  logic done;
  logic [14:0] bits;
  logic busy;
  modport rx (output done, output bits, output busy);
  modport use_side (input done, input bits, input busy);
endinterface : rxcfg_frame_if

//--- design/rxcfg_frame_rx.sv
`timescale 1ns/1ps
module rxcfg_frame_rx
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // synchronised line level and gating
  input wire logic line_in,
  input wire logic enable,
  // sync pulse request toward the pad
  output logic sync_pull,
  // frame out
  rxcfg_frame_if.rx frm
);
  import rxcfg_pkg::*;
  typedef enum logic [2:0] {RXCFG_F_IDLE, RXCFG_F_LOW, RXCFG_F_WAITHI, RXCFG_F_SYNC,
    RXCFG_F_SAMPLE} rxcfg_fstate_t;
  rxcfg_fstate_t state;
  logic [15:0] cnt;
  logic [3:0] idx;
  logic [14:0] shreg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= RXCFG_F_IDLE;
      cnt <= 16'h0000;
      idx <= 4'h0;
      shreg <= 15'h0000;
      frm.done <= 1'b0;
      frm.bits <= 15'h0000;
    end
    else
    begin
      frm.done <= 1'b0;
      case (state)
        RXCFG_F_IDLE:
        begin
          cnt <= 16'h0000;
          if (enable && !line_in)
            state <= RXCFG_F_LOW;
        end
        RXCFG_F_LOW:
        begin
          // a low shorter than the minimum is a data glitch, not a frame
          if (line_in)
            state <= RXCFG_F_IDLE;
          else if (cnt == 16'(START_LOW_MIN_CYC))
            state <= RXCFG_F_WAITHI;
          else
            cnt <= cnt + 16'h0001;
        end
        RXCFG_F_WAITHI:
          if (line_in)
          begin
            idx <= 4'h0;
            cnt <= 16'h0000;
            state <= RXCFG_F_SYNC;
          end
        RXCFG_F_SYNC:
        begin
          // device pulls low briefly, then host sets the bit level
          if (cnt == 16'(SYNC_CYC * 2))
          begin
            cnt <= 16'h0000;
            state <= RXCFG_F_SAMPLE;
          end
          else
            cnt <= cnt + 16'h0001;
        end
        RXCFG_F_SAMPLE:
        begin
          shreg[14 - idx] <= line_in;
          if (idx == 4'd0 && line_in)
          begin
            // off command carries a single sync pulse
            frm.bits <= 15'h4000;
            frm.done <= 1'b1;
            state <= RXCFG_F_IDLE;
          end
          else if (idx == 4'(FRAME_BITS - 1))
          begin
            frm.bits <= {shreg[14:1], line_in};
            frm.done <= 1'b1;
            state <= RXCFG_F_IDLE;
          end
          else
          begin
            idx <= idx + 4'h1;
            state <= RXCFG_F_SYNC;
          end
        end
        default: state <= RXCFG_F_IDLE;
      endcase
    end
  end

  assign sync_pull = (state == RXCFG_F_SYNC) && (cnt < 16'(SYNC_CYC));
  assign frm.busy = (state != RXCFG_F_IDLE);
endmodule : rxcfg_frame_rx

//--- design/rxcfg_top.sv
`timescale 1ns/1ps
module rxcfg_top
#(
  parameter int SLEEP_UNIT = rxcfg_pkg::SLEEP_UNIT_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // supply monitor, asserted when register contents may be lost
  input wire logic supply_dip,
  // data pad, open drain
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  // polling control pin, low means controller holds receiver on
  input wire logic polling_n,
  // demodulator side
  input wire logic demod_bit,
  input wire logic stream_valid,
  input wire logic check_pass,
  input wire logic last_high,
  input wire logic clk_event,
  // data clock output
  output logic data_clk,
  // status and decoded configuration
  output rxcfg_pkg::rxcfg_mode_t mode,
  output logic [3:0] check_count,
  output logic [3:0] window_scale,
  output logic modulation_sel,
  output logic [5:0] lim_lower,
  output logic [5:0] lim_upper,
  output logic loss_marker
);
  import rxcfg_pkg::*;

  logic [11:0] operating_config;
  logic [11:0] bit_check_limits;
  logic [1:0] data_sync;
  logic [1:0] poll_sync;
  logic [1:0] dip_sync;
  logic line;
  logic poll_low;
  logic sync_pull;
  logic drive_data;
  logic out_level;
  logic end_pulse;
  logic [7:0] pulse_cnt;
  logic stream_q;
  logic clk_pend;
  logic [7:0] clk_cnt;
  logic [2:0] clk_hi;
  logic [17:0] sleep_cnt;
  logic off_check;
  logic [1:0] baud_range_sel;
  logic noise_sup;
  logic sleep_extend;
  logic [4:0] sleep_val;
  rxcfg_cmd_t cmd;
  rxcfg_frame_if frm ();

  // pad and pin inputs pass two flops before any use
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_sync <= 2'b11;
      poll_sync <= 2'b11;
      dip_sync <= 2'b00;
    end
    else
    begin
      data_sync <= {data_sync[0], data_in};
      poll_sync <= {poll_sync[0], polling_n};
      dip_sync <= {dip_sync[0], supply_dip};
    end
  end

  assign line = data_sync[1];
  assign poll_low = !poll_sync[1];

  // field decode
  assign baud_range_sel = operating_config[OP_BAUD_LSB +: 2];
  assign window_scale = rxcfg_scale(baud_range_sel);
  assign check_count = poll_low ? 4'd0 : rxcfg_checks(operating_config[OP_CHECK_LSB +: 2]);
  assign modulation_sel = operating_config[OP_MOD_BIT];
  assign sleep_val = operating_config[OP_SLEEP_LSB +: 5];
  assign sleep_extend = operating_config[OP_EXT_BIT];
  assign noise_sup = operating_config[OP_NS_BIT];
  assign lim_lower = bit_check_limits[LIM_LO_LSB +: 6];
  assign lim_upper = bit_check_limits[5:0];

  rxcfg_frame_rx u_frame (
    .clk(clk),
    .rstn(rstn),
    .line_in(line),
    .enable(!drive_data || out_level),
    .sync_pull(sync_pull),
    .frm(frm.rx)
  );

  always_comb
  begin
    if (frm.bits[14])
      cmd = RXCFG_CMD_OFF;
    else if (frm.bits[13])
      cmd = RXCFG_CMD_OP;
    else
      cmd = RXCFG_CMD_LIM;
  end

  // configuration registers; defaults on power-on or on a supply dip
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      operating_config <= OP_RESET;
      bit_check_limits <= LIM_RESET;
    end
    else if (dip_sync[1])
    begin
      operating_config <= OP_RESET;
      bit_check_limits <= LIM_RESET;
    end
    else if (frm.done && !frm.bits[0])
    begin
      if (cmd == RXCFG_CMD_OP)
        operating_config <= frm.bits[12:1];
      else if (cmd == RXCFG_CMD_LIM)
        bit_check_limits <= frm.bits[12:1];
    end
  end

  // marker stands until the controller reprograms a register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      loss_marker <= 1'b0;
    else if (dip_sync[1])
      loss_marker <= 1'b1;
    else if (frm.done && !frm.bits[0] && cmd != RXCFG_CMD_OFF)
      loss_marker <= 1'b0;
  end

  // receiver mode sequencing
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode <= RXCFG_POLL;
      sleep_cnt <= 18'h00000;
      stream_q <= 1'b0;
      off_check <= 1'b0;
    end
    else
    begin
      stream_q <= stream_valid;
      case (mode)
        RXCFG_POLL:
        begin
          // 31 holds sleep forever; only the pin wakes it
          if (poll_low)
            mode <= RXCFG_STARTUP;
          else if (sleep_val == 5'd31)
            sleep_cnt <= 18'h00000;
          else if (sleep_cnt >= 18'(sleep_val * (sleep_extend ? 8 : 1) * SLEEP_UNIT))
          begin
            sleep_cnt <= 18'h00000;
            mode <= RXCFG_STARTUP;
          end
          else
            sleep_cnt <= sleep_cnt + 18'h00001;
        end
        RXCFG_STARTUP:
          mode <= RXCFG_CHECK;
        RXCFG_CHECK:
          // an off under a held pin still waits for a real check
          if (check_pass || (check_count == 4'd0 && !off_check))
          begin
            mode <= RXCFG_RECV;
            off_check <= 1'b0;
          end
        RXCFG_RECV:
        begin
          if (frm.done && cmd == RXCFG_CMD_OFF)
          begin
            mode <= poll_low ? RXCFG_STARTUP : RXCFG_POLL;
            off_check <= poll_low;
          end
          else if (stream_q && !stream_valid && noise_sup)
            mode <= RXCFG_CHECK;
          // with suppression off the receiver stays here until told
        end
        default: mode <= RXCFG_POLL;
      endcase
    end
  end

  // trailing pulse when the stream ends on a high period
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pulse_cnt <= 8'h00;
      end_pulse <= 1'b0;
    end
    else if (mode == RXCFG_RECV && stream_q && !stream_valid && noise_sup && last_high)
    begin
      // counter runs down to zero inclusive, so load one less
      pulse_cnt <= 8'(END_PULSE_BASE_CYC * window_scale - 1);
      end_pulse <= 1'b1;
    end
    else if (pulse_cnt != 8'h00)
      pulse_cnt <= pulse_cnt - 8'h01;
    else
      end_pulse <= 1'b0;
  end

  // data pad output register; high means released
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_level <= 1'b1;
    else if (sync_pull)
      out_level <= 1'b0;
    else if (end_pulse)
      out_level <= 1'b0;
    else if (mode == RXCFG_RECV && !frm.busy)
      out_level <= demod_bit;
    else
      out_level <= 1'b1;
  end

  assign drive_data = !out_level;
  assign data_out = 1'b0;
  assign data_oe = drive_data;

  // data clock: wait for pad to follow, then fixed delay
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_pend <= 1'b0;
      clk_cnt <= 8'h00;
      clk_hi <= 3'h0;
      data_clk <= 1'b0;
    end
    else
    begin
      if (clk_event && mode == RXCFG_RECV)
      begin
        clk_pend <= 1'b1;
        clk_cnt <= 8'h00;
      end
      else if (clk_pend && line == out_level)
      begin
        if (clk_cnt == 8'(CLOCK_ISSUE_CYC - 1))
        begin
          clk_pend <= 1'b0;
          clk_hi <= 3'(CLK_PULSE_CYC);
        end
        else
          clk_cnt <= clk_cnt + 8'h01;
      end
      if (clk_hi != 3'h0)
        clk_hi <= clk_hi - 3'h1;
      data_clk <= (clk_hi != 3'h0);
    end
  end
endmodule : rxcfg_top

//--- verification/rxcfg_top_props.sv
`timescale 1ns/1ps
module rxcfg_top_props
#(
  parameter int SLEEP_UNIT = rxcfg_pkg::SLEEP_UNIT_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins and demodulator side
  input wire logic supply_dip,
  input wire logic data_in,
  input wire logic data_oe,
  input wire logic polling_n,
  input wire logic stream_valid,
  input wire logic check_pass,
  input wire logic clk_event,
  // outputs
  input wire logic data_clk,
  input wire rxcfg_pkg::rxcfg_mode_t mode,
  input wire logic [3:0] check_count,
  input wire logic [3:0] window_scale,
  input wire logic modulation_sel,
  input wire logic [5:0] lim_lower,
  input wire logic [5:0] lim_upper,
  input wire logic loss_marker
);
  import rxcfg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_clk4;
    data_clk [*4] ##1 !data_clk;
  endsequence
  sequence s_sync;
    data_oe [*8] ##1 !data_oe;
  endsequence
  property p_clk_len;
    $rose(data_clk) |-> s_clk4;
  endproperty
  a_clk_len: assert property (p_clk_len) else $error("data clock pulse length wrong");
  property p_clk_delay;
    mode == RXCFG_RECV && clk_event && data_in && !data_oe |-> ##[9:16] data_clk;
  endproperty
  a_clk_delay: assert property (p_clk_delay) else $error("data clock not issued");
  property p_stream_end;
    mode == RXCFG_RECV && $fell(stream_valid) |-> ##[1:4] mode inside {RXCFG_RECV, RXCFG_CHECK};
  endproperty
  a_stream_end: assert property (p_stream_end) else $error("bad mode after stream");
  property p_pass;
    mode == RXCFG_CHECK && check_pass |-> ##[1:3] mode == RXCFG_RECV;
  endproperty
  a_pass: assert property (p_pass) else $error("no return to receiving");
  property p_por;
    $rose(rstn) |-> window_scale == 4'h8 && !modulation_sel && lim_lower == 6'h15
      && lim_upper == 6'h29 && mode == RXCFG_POLL;
  endproperty
  a_por: assert property (p_por) else $error("reset values wrong");
  property p_dip;
    $rose(supply_dip) |-> ##[1:5] loss_marker;
  endproperty
  a_dip: assert property (p_dip) else $error("marker not raised");
  property p_dip_def;
    $rose(loss_marker) |-> ##[0:1] lim_lower == 6'h15 && lim_upper == 6'h29 && window_scale == 4'h8;
  endproperty
  a_dip_def: assert property (p_dip_def) else $error("defaults not reloaded");
  property p_hold_low;
    (!polling_n) [*4] |-> check_count == 4'h0;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("check active while held");
  property p_sync;
    $rose(data_oe) && mode != RXCFG_RECV |-> s_sync;
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse length wrong");
endmodule : rxcfg_top_props
bind rxcfg_top rxcfg_top_props #(.SLEEP_UNIT(SLEEP_UNIT)) u_props (.clk, .rstn, .supply_dip,
  .data_in, .data_oe, .polling_n, .stream_valid, .check_pass, .clk_event, .data_clk, .mode,
  .check_count, .window_scale, .modulation_sel, .lim_lower, .lim_upper, .loss_marker);

//--- verification/rxcfg_host_model.sv
`timescale 1ns/1ps
module rxcfg_host_model
(
  // clock and pad
  input wire logic clk,
  input wire logic data_oe,
  // host side of the pins
  output logic host_low,
  output logic polling_n
);
  initial {host_low, polling_n} = 2'b01;
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // f[14] is frame bit 1, f[0] the stop bit; released line floats high
  task automatic send(input logic [14:0] f);
    host_low = 1'b1;
    repeat (70) tick();
    host_low = 1'b0;
    for (int i = 14; i >= 0; i--)
    begin
      while (!data_oe) tick();
      while (data_oe) tick();
      host_low = !f[i];
      repeat (10) tick();
      host_low = 1'b0;
      if (f[14]) break;
    end
  endtask : send
endmodule : rxcfg_host_model

//--- verification/tb_rx_config_and_noise_control.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((e) !== (a)) begin bad_count++; $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module tb_rx_config_and_noise_control;
  import rxcfg_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, supply_dip = 1'b0, stream_valid = 1'b0, loss = 1'b0;
  logic check_pass = 1'b0, clk_event = 1'b0, demod_bit = 1'b1, last_high = 1'b0;
  logic data_out, data_oe, data_clk, modulation_sel, loss_marker, host_low, polling_n;
  logic [3:0] check_count, window_scale;
  logic [5:0] lim_lower, lim_upper;
  logic [11:0] op = 12'h119, lim = 12'h569;
  logic [22:0] q[$];
  logic [22:0] item;
  rxcfg_mode_t mode;
  int checks = 0, bad_count = 0;
  bit [31:0] r;
  event look;
  wire logic data_in = !(data_oe && !data_out) && !host_low;
  always #5 clk = ~clk;
  // short sleep unit keeps the poll timer inside the run
  rxcfg_top #(.SLEEP_UNIT(4)) dut (.clk, .rstn, .supply_dip, .data_in, .data_out, .data_oe,
    .polling_n, .demod_bit, .stream_valid, .check_pass, .last_high, .clk_event, .data_clk,
    .mode, .check_count, .window_scale, .modulation_sel, .lim_lower, .lim_upper, .loss_marker);
  rxcfg_host_model host (.clk, .data_oe, .host_low, .polling_n);
  function automatic logic [21:0] want();
    return {(polling_n ? {2'b00, op[9:8]} * 4'h3 : 4'h0), 4'h8 >> op[11:10], op[7], lim, loss};
  endfunction : want
  function automatic logic [21:0] got();
    return {check_count, window_scale, modulation_sel, lim_lower, lim_upper, loss_marker};
  endfunction : got
  always @(look)
    while (q.size() > 0)
    begin
      item = q.pop_front();
      if (!item[22]) `CHK("config", item[21:0], got())
      else if (item[21]) `CHK("data_oe", item[0], data_oe)
      else if (item[20]) `CHK("data_clk", item[0], data_clk)
      else `CHK("mode", item[1:0], mode)
    end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic note(input logic k, input logic [21:0] v);
    q.push_back({k, v});
    -> look;
  endtask : note
  task automatic await(input rxcfg_mode_t m, input int n);
    for (int i = 0; i < n && mode !== m; i++) tick();
    note(1'b1, 22'(m));
  endtask : await
  task automatic wr(input logic sel, input logic [11:0] v, input logic stop);
    host.send({1'b0, sel, v, stop});
    tick(4);
    if (!stop)
    begin
      if (sel) op = v;
      else lim = v;
      loss = 1'b0;
    end
    note(1'b0, want());
  endtask : wr
  task automatic to_recv();
    for (int i = 0; i < 400 && !(mode inside {RXCFG_CHECK, RXCFG_RECV}); i++) tick();
    check_pass = 1'b1;
    tick();
    check_pass = 1'b0;
    await(RXCFG_RECV, 10);
  endtask : to_recv
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    r = $urandom(32'hbcb4);
    tick(3);
    rstn = 1'b1;
    tick(3);
    note(1'b0, want());
    // default sleep 6 x 1 x unit 4: poll ends on the 25th edge after release
    tick(6 * 4 - 3);
    note(1'b1, 22'(RXCFG_POLL));
    tick();
    note(1'b1, 22'(RXCFG_STARTUP));
    $display("defaults done");
    for (int b = 0; b < 4; b++)
    begin
      r = $urandom;
      wr(1'b1, {b[1:0], r[8:0], 1'b1}, 1'b0);
    end
    r = $urandom;
    wr(1'b0, r[11:0], 1'b0);
    wr(1'b0, ~r[11:0], 1'b1);
    wr(1'b1, 12'h119, 1'b1);
    $display("register writes done");
    supply_dip = 1'b1;
    tick(4);
    supply_dip = 1'b0;
    {op, lim, loss} = {12'h119, 12'h569, 1'b1};
    tick(2);
    note(1'b0, want());
    wr(1'b0, 12'h5aa, 1'b0);
    $display("supply dip done");
    host.polling_n = 1'b0;
    to_recv();
    last_high = 1'b1;
    stream_valid = 1'b1;
    tick(6);
    stream_valid = 1'b0;
    await(RXCFG_CHECK, 8);
    // trailing pulse is base x 8 cycles at the default baud range
    tick();
    note(1'b1, 22'h200001);
    tick(END_PULSE_BASE_CYC * 8 - 1);
    note(1'b1, 22'h200001);
    tick();
    note(1'b1, 22'h200000);
    last_high = 1'b0;
    to_recv();
    clk_event = 1'b1;
    tick();
    clk_event = 1'b0;
    tick(CLOCK_ISSUE_CYC);
    note(1'b1, 22'h100000);
    tick();
    note(1'b1, 22'h100001);
    tick(CLK_PULSE_CYC);
    note(1'b1, 22'h100000);
    tick(5);
    host.send(15'h4000);
    await(RXCFG_STARTUP, 300);
    tick(3);
    note(1'b1, 22'(RXCFG_CHECK));
    wr(1'b1, 12'h118, 1'b0);
    to_recv();
    stream_valid = 1'b1;
    tick(6);
    stream_valid = 1'b0;
    tick(6);
    note(1'b1, 22'(RXCFG_RECV));
    host.polling_n = 1'b1;
    tick(4);
    host.send(15'h7fff);
    await(RXCFG_POLL, 300);
    $display("mode tests done");
    end_of_test();
  end
  initial
  begin
    tick(60000);
    bad_count++;
    end_of_test();
  end
endmodule : tb_rx_config_and_noise_control
